// >>> wiu_chk.sv
// Purpose: Port checks for the wake line unit
// Assumes: Register shadows follow bus writes
// Notes:   Pin path judged after five quiet cycles
`default_nettype none
module wiu_chk (
  input wire logic       mclk_in,
  input wire logic       rst_n_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wdata_in,
  input wire logic       wr_in,
  input wire logic       rd_in,
  input wire logic [7:0] rdata_out,
  input wire logic       ext_int_pin_in,
  input wire logic       stop_ack_in,
  input wire logic       stop_req_out,
  input wire logic       wake_event_out,
  input wire logic       channel_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic        wm_ff;
  logic        src_ff;
  logic [15:0] mask_ff;
  logic [2:0]  quiet_ff;
  wire logic   ctl_wr = wr_in && addr_in == wiu_pkg::ADDR_CONTROL;
  wire logic   seq_wr = ctl_wr && wdata_in[2];
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      wm_ff    <= 1'b0;
      src_ff   <= 1'b0;
      mask_ff  <= 16'h0000;
      quiet_ff <= 3'h0;
    end
    else
    begin
      if (ctl_wr) {src_ff, wm_ff} <= wdata_in[1:0];
      if (wr_in && addr_in == wiu_pkg::ADDR_MASK_HI) mask_ff[15:8] <= wdata_in;
      if (wr_in && addr_in == wiu_pkg::ADDR_MASK_LO) mask_ff[7:0] <= wdata_in;
      // Saturate so a long quiet spell never wraps
      if (src_ff || ext_int_pin_in) quiet_ff <= 3'h0;
      else if (quiet_ff != 3'h7) quiet_ff <= quiet_ff + 3'h1;
    end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  property p_seq; $rose(stop_req_out) |-> $past(seq_wr) || $past(seq_wr, 2); endproperty
  property p_accept; $rose(stop_req_out) |-> wm_ff && mask_ff != 16'h0000 && !$past(wake_event_out); endproperty
  property p_wake; stop_req_out && wake_event_out |-> ##[1:2] !stop_req_out; endproperty
  property p_hold; stop_req_out && stop_ack_in && !wake_event_out |=> stop_req_out; endproperty
  property p_cancel; stop_req_out && wr_in && !stop_ack_in |-> ##[1:2] !stop_req_out; endproperty
  property p_mode; !wm_ff |-> !wake_event_out; endproperty
  property p_mask; mask_ff == 16'h0000 |-> !wake_event_out; endproperty
  property p_pin; quiet_ff >= 3'h5 |-> !channel_out; endproperty
  property p_rd; !$past(rd_in) |-> rdata_out == 8'h00; endproperty
  a_seq: assert property (p_seq) else $error("stop request without sleep write");
  a_accept: assert property (p_accept) else $error("stop accepted wrongly");
  a_wake: assert property (p_wake) else $error("wake did not end stop");
  a_hold: assert property (p_hold) else $error("stop ended without wake");
  a_cancel: assert property (p_cancel) else $error("write did not block stop");
  a_mode: assert property (p_mode) else $error("wake event outside wake mode");
  a_mask: assert property (p_mask) else $error("wake event from masked lines");
  a_pin: assert property (p_pin) else $error("channel high with pin source low");
  a_rd: assert property (p_rd) else $error("read data outside read slot");
  c_stop: cover property ($rose(stop_req_out));
  c_wake: cover property (stop_req_out && wake_event_out);
  c_chan: cover property ($rose(channel_out));
endmodule
`default_nettype wire

// >>> wiu_far.sv
// Purpose: Clock unit and interrupt channel seen from the unit
// Assumes: Stop entry lags the request by a few cycles
// Notes:   Counts rising channel edges only
`default_nettype none
module wiu_far #(
  parameter int ACK_DLY = 3
) (
  input  wire logic mclk_in,
  input  wire logic rst_n_in,
  input  wire logic stop_req_in,
  input  wire logic channel_in,
  output logic      stop_ack_out,
  output int        edges_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] sh_ff;
  logic       ch_ff;
  // Stopped only after the delay; released at once on wake
  assign stop_ack_out = stop_req_in && sh_ff[ACK_DLY-1];
  always_ff @(posedge mclk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      sh_ff     <= 8'h00;
      ch_ff     <= 1'b0;
      edges_out <= 0;
    end
    else
    begin
      sh_ff <= {sh_ff[6:0], stop_req_in};
      ch_ff <= channel_in;
      if (channel_in && !ch_ff) edges_out <= edges_out + 1;
    end
endmodule
`default_nettype wire

// >>> wiu_pkg.sv
// Purpose: Constants for the wake-up / interrupt line unit
// Assumes: 8-bit register port, byte addresses as printed
// Notes:   Pending registers sit at the two addresses after the polarity pair
`default_nettype none
package wiu_pkg;
  localparam int          ADDR_W          = 8;
  localparam int          DATA_W          = 8;
  localparam int          LINES           = 16;
  localparam logic [7:0]  ADDR_CONTROL    = 8'hF9;
  localparam logic [7:0]  ADDR_MASK_HI    = 8'hFA;
  localparam logic [7:0]  ADDR_MASK_LO    = 8'hFB;
  localparam logic [7:0]  ADDR_POL_HI     = 8'hFC;
  localparam logic [7:0]  ADDR_POL_LO     = 8'hFD;
  localparam logic [7:0]  ADDR_PEND_HI    = 8'hFE;
  localparam logic [7:0]  ADDR_PEND_LO    = 8'hFF;
  localparam int          BIT_WAKE_MODE   = 0;
  localparam int          BIT_SRC_SEL     = 1;
  localparam int          BIT_SLEEP       = 2;
  localparam logic [7:0]  RST_REG         = 8'h00;
  localparam logic [15:0] RST_LINES       = 16'h0000;
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_GOT1,
    SEQ_GOT10,
    SEQ_STOPPED
  } wiu_seq_e;
endpackage
`default_nettype wire

// >>> wiu_top.sv
// Purpose: Sixteen edge-triggered wake-up / interrupt lines with guarded sleep entry
// Assumes: wake_line_in and ext_int_pin_in are asynchronous pins
// Notes:   stop_req_out tells the clock unit to stop; stop_ack_in says it has stopped
//
// Chosen here: the address-and-strobe port.
`default_nettype none
module wiu_top #(
  parameter int LINES = wiu_pkg::LINES
) (
  input  wire logic                       mclk_in,
  input  wire logic                       rst_n_in,
  input  wire logic [wiu_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [wiu_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_in,
  input  wire logic                       rd_in,
  output logic      [wiu_pkg::DATA_W-1:0] rdata_out,
  input  wire logic [LINES-1:0]           wake_line_in,
  input  wire logic                       ext_int_pin_in,
  input  wire logic                       stop_ack_in,
  output logic                            stop_req_out,
  output logic                            wake_event_out,
  output logic                            channel_out
);

  typedef wiu_pkg::wiu_seq_e wiu_seq_state_t;

  logic [LINES-1:0] line_s1_ff;
  logic [LINES-1:0] line_s2_ff;
  logic [LINES-1:0] line_d_ff;
  logic             pin_s1_ff;
  logic             pin_s2_ff;
  logic [7:0]       ctrl_ff;
  logic [7:0]       nxt_ctrl;
  logic [15:0]      mask_ff;
  logic [15:0]      nxt_mask;
  logic [15:0]      pol_ff;
  logic [15:0]      nxt_pol;
  logic [15:0]      pend_ff;
  logic [15:0]      nxt_pend;
  wiu_seq_state_t   seq_ff;
  logic [7:0]       rdata_ff;
  logic             chan_ff;

  // Write decode shared by every register
  function automatic logic wr_hit
  (
    input logic                       wr,
    input logic [wiu_pkg::ADDR_W-1:0] addr,
    input logic [wiu_pkg::ADDR_W-1:0] target
  );
    wr_hit = wr && (addr == target);
  endfunction

  wire        wr_ctrl   = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_CONTROL);
  wire        wr_mhi    = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_MASK_HI);
  wire        wr_mlo    = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_MASK_LO);
  wire        wr_phi    = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_POL_HI);
  wire        wr_plo    = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_POL_LO);
  wire        wr_dhi    = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_PEND_HI);
  wire        wr_dlo    = wr_hit(wr_in, addr_in, wiu_pkg::ADDR_PEND_LO);
  wire        wbit      = wdata_in[wiu_pkg::BIT_SLEEP];
  wire        wake_mode = ctrl_ff[wiu_pkg::BIT_WAKE_MODE];
  wire        src_sel   = ctrl_ff[wiu_pkg::BIT_SRC_SEL];

  // Edge detect on synchronised lines; an edge during a polarity write is dropped
  wire [15:0] rise      = line_s2_ff & ~line_d_ff;
  wire [15:0] fall      = ~line_s2_ff & line_d_ff;
  wire [15:0] trig      = (pol_ff & rise) | (~pol_ff & fall);
  wire        pol_wr    = wr_phi || wr_plo;
  wire [15:0] hw_set    = pol_wr ? 16'h0000 : trig;

  wire [15:0] armed     = pend_ff & mask_ff;
  wire        any_armed = |armed;
  // Wake event needs wake mode regardless of source select
  wire        wake_evt  = wake_mode && any_armed;
  wire        accept_ok = wake_mode && !any_armed && (|mask_ff);

  // Per-line request while source select is set; the channel sees pin or lines
  wire        line_req  = src_sel && any_armed;
  wire        chan_src  = src_sel ? line_req : pin_s2_ff;

  // Pending register writes: software data, with hardware set winning over clear
  always_comb
  begin
    nxt_pend = pend_ff;
    if (wr_dhi)
    begin
      nxt_pend[15:8] = wdata_in;
    end
    if (wr_dlo)
    begin
      nxt_pend[7:0] = wdata_in;
    end
    // A trigger in the same cycle as a software clear must not be lost
    nxt_pend = nxt_pend | hw_set;
  end

  always_comb
  begin
    nxt_mask = mask_ff;
    if (wr_mhi)
    begin
      nxt_mask[15:8] = wdata_in;
    end
    if (wr_mlo)
    begin
      nxt_mask[7:0] = wdata_in;
    end
  end

  always_comb
  begin
    nxt_pol = pol_ff;
    if (wr_phi)
    begin
      nxt_pol[15:8] = wdata_in;
    end
    if (wr_plo)
    begin
      nxt_pol[7:0] = wdata_in;
    end
  end

  // Sleep sequence: control byte keeps mode and source; sleep bit follows sequencer.
  // A repeated 1 restarts the sequence; any write to another address breaks it.
  logic           sleep_bit;
  wiu_seq_state_t nxt_seq;
  always_comb
  begin
    nxt_seq = seq_ff;
    unique case (seq_ff)
      wiu_pkg::SEQ_IDLE:
      begin
        if (wr_ctrl && wbit)
        begin
          nxt_seq = wiu_pkg::SEQ_GOT1;
        end
      end
      wiu_pkg::SEQ_GOT1:
      begin
        if (wr_ctrl && !wbit)
        begin
          nxt_seq = wiu_pkg::SEQ_GOT10;
        end
        else if (wr_ctrl && wbit)
        begin
          nxt_seq = wiu_pkg::SEQ_GOT1;
        end
        else if (wr_in)
        begin
          nxt_seq = wiu_pkg::SEQ_IDLE;
        end
      end
      wiu_pkg::SEQ_GOT10:
      begin
        if (wr_ctrl && wbit && accept_ok)
        begin
          nxt_seq = wiu_pkg::SEQ_STOPPED;
        end
        else if (wr_in)
        begin
          // Refused or broken: back to idle, so the sleep bit reads clear
          nxt_seq = wiu_pkg::SEQ_IDLE;
        end
      end
      wiu_pkg::SEQ_STOPPED:
      begin
        // Wake wins over a write-cancel in the same cycle
        if (wake_evt)
        begin
          nxt_seq = wiu_pkg::SEQ_IDLE;
        end
        else if (wr_in && !stop_ack_in)
        begin
          // Until the clock unit confirms the stop, a write still blocks entry
          nxt_seq = wiu_pkg::SEQ_IDLE;
        end
      end
    endcase
  end

  assign sleep_bit = (seq_ff == wiu_pkg::SEQ_GOT1) || (seq_ff == wiu_pkg::SEQ_STOPPED);

  always_comb
  begin
    nxt_ctrl = ctrl_ff;
    if (wr_ctrl)
    begin
      nxt_ctrl[wiu_pkg::BIT_WAKE_MODE] = wdata_in[wiu_pkg::BIT_WAKE_MODE];
      nxt_ctrl[wiu_pkg::BIT_SRC_SEL]   = wdata_in[wiu_pkg::BIT_SRC_SEL];
    end
  end

  // Read mux; unmapped addresses read zero
  logic [7:0] rd_mux;
  always_comb
  begin
    rd_mux = 8'h00;
    unique case (addr_in)
      wiu_pkg::ADDR_CONTROL: rd_mux = {5'h00, sleep_bit, src_sel, wake_mode};
      wiu_pkg::ADDR_MASK_HI: rd_mux = mask_ff[15:8];
      wiu_pkg::ADDR_MASK_LO: rd_mux = mask_ff[7:0];
      wiu_pkg::ADDR_POL_HI:  rd_mux = pol_ff[15:8];
      wiu_pkg::ADDR_POL_LO:  rd_mux = pol_ff[7:0];
      wiu_pkg::ADDR_PEND_HI: rd_mux = pend_ff[15:8];
      wiu_pkg::ADDR_PEND_LO: rd_mux = pend_ff[7:0];
      default:               rd_mux = 8'h00;
    endcase
  end

  // Synchronisers; second stage only feeds logic
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      line_s1_ff <= wiu_pkg::RST_LINES;
      line_s2_ff <= wiu_pkg::RST_LINES;
      line_d_ff  <= wiu_pkg::RST_LINES;
    end
    else
    begin
      line_s1_ff <= wake_line_in;
      line_s2_ff <= line_s1_ff;
      line_d_ff  <= line_s2_ff;
    end
  end

  // Pin path has no edge stage; the channel consumer finds the edge itself
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pin_s1_ff <= 1'b0;
      pin_s2_ff <= 1'b0;
    end
    else
    begin
      pin_s1_ff <= ext_int_pin_in;
      pin_s2_ff <= pin_s1_ff;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_ff <= wiu_pkg::RST_REG;
      mask_ff <= wiu_pkg::RST_LINES;
      pol_ff  <= wiu_pkg::RST_LINES;
    end
    else
    begin
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      pol_ff  <= nxt_pol;
    end
  end

  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_ff <= wiu_pkg::RST_LINES;
      seq_ff  <= wiu_pkg::SEQ_IDLE;
    end
    else
    begin
      pend_ff <= nxt_pend;
      seq_ff  <= nxt_seq;
    end
  end

  // Read data stand only in the cycle after the strobe, zero otherwise
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rdata_ff <= wiu_pkg::RST_REG;
      chan_ff  <= 1'b0;
    end
    else
    begin
      rdata_ff <= rd_in ? rd_mux : 8'h00;
      chan_ff  <= chan_src;
    end
  end

  // With source select set, an armed pending clear that leaves others set pulls the channel low for one cycle,
  // so the consumer sees a fresh rising edge
  wire clr_any  = |(pend_ff & ~nxt_pend & mask_ff);
  logic gap_ff;
  always_ff @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      gap_ff <= 1'b0;
    end
    else
    begin
      gap_ff <= src_sel && clr_any;
    end
  end

  assign rdata_out      = rdata_ff;
  assign stop_req_out   = (seq_ff == wiu_pkg::SEQ_STOPPED);
  assign wake_event_out = wake_evt;
  assign channel_out    = chan_ff && !gap_ff;

endmodule
`default_nettype wire

// >>> wiu_top_bench.sv
// Purpose: Register level tests of the wake line unit
// Assumes: Pins change only at clock edges, glitch free
// Notes:   Reads sample one cycle after the strobe
`default_nettype none
module wiu_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk_in, rst_n_in, wr_in, rd_in, ext_int_pin_in, stop_ack_in;
  logic stop_req_out, wake_event_out, channel_out;
  logic [7:0] addr_in, wdata_in, rdata_out;
  logic [15:0] wake_line_in;
  int edges, e, failures, checks;
  wiu_top DUT (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .wake_line_in,
    .ext_int_pin_in, .stop_ack_in, .stop_req_out, .wake_event_out, .channel_out);
  wiu_far FAR (.mclk_in, .rst_n_in, .stop_req_in(stop_req_out), .channel_in(channel_out),
    .stop_ack_out(stop_ack_in), .edges_out(edges));
  task automatic chk(input string what, input logic [15:0] got, exp);
    checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s exp %h got %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge mclk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1 chk("reg", {8'h00, rdata_out}, {8'h00, exp});
  endtask
  // Sleep sequence, optionally broken by a foreign write
  task automatic seq(input logic [7:0] w, input logic cut);
    wr(8'hF9, w | 8'h04);
    rd(8'hF9, w | 8'h04);
    if (cut) wr(8'hFA, 8'h00);
    wr(8'hF9, w);
    wr(8'hF9, w | 8'h04);
  endtask
  task stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial
  begin
    #2000000;
    failures++;
    stop_test();
  end
  initial
  begin
    {rst_n_in, wr_in, rd_in, ext_int_pin_in, addr_in, wdata_in} = '0;
    wake_line_in = 16'h0002;
    cyc(8);
    rst_n_in <= 1'b1;
    for (int a = 'hF9; a <= 'hFF; a++) rd(a[7:0], 8'h00);
    rd(8'h10, 8'h00);
    wr(8'hFA, 8'hFF);
    wr(8'hFB, 8'hFF);
    wr(8'hFD, 8'h01);
    rd(8'hFD, 8'h01);
    wake_line_in <= 16'h0005;
    cyc(6);
    rd(8'hFF, 8'h03);
    wr(8'hF9, 8'h02);
    cyc(4);
    chk("chan", {15'h0, channel_out}, 16'h0001);
    e = edges;
    wr(8'hFF, 8'h02);
    cyc(4);
    chk("edges", edges[15:0], e[15:0] + 16'h0001);
    wr(8'hFF, 8'h00);
    cyc(4);
    chk("chan", {15'h0, channel_out}, 16'h0000);
    wr(8'hF9, 8'h00);
    wr(8'hFF, 8'h01);
    ext_int_pin_in <= 1'b1;
    cyc(5);
    chk("pin", {15'h0, channel_out}, 16'h0001);
    ext_int_pin_in <= 1'b0;
    rd(8'hFF, 8'h01);
    wr(8'hFA, 8'h00);
    for (int i = 0; i < 3; i++)
    begin
      wr(8'hFB, i == 2 ? 8'h00 : 8'h01);
      wr(8'hFF, i == 1 ? 8'h01 : 8'h00);
      seq(i == 0 ? 8'h00 : 8'h01, 1'b0);
      cyc(2);
      chk("refuse", {15'h0, stop_req_out}, 16'h0000);
      rd(8'hF9, i == 0 ? 8'h00 : 8'h01);
    end
    wr(8'hFB, 8'h01);
    wr(8'hFF, 8'h00);
    seq(8'h01, 1'b1);
    cyc(2);
    chk("cut", {15'h0, stop_req_out}, 16'h0000);
    seq(8'h01, 1'b0);
    wr(8'hFC, 8'h00);
    cyc(2);
    chk("late", {15'h0, stop_req_out}, 16'h0000);
    seq(8'h01, 1'b0);
    cyc(6);
    chk("stop", {14'h0, stop_req_out, stop_ack_in}, 16'h0003);
    rd(8'hF9, 8'h05);
    wake_line_in <= 16'h0004;
    cyc(2);
    wake_line_in <= 16'h0005;
    cyc(6);
    chk("wake", {14'h0, stop_req_out, stop_ack_in}, 16'h0000);
    rd(8'hF9, 8'h01);
    rd(8'hFF, 8'h01);
    // Rising edge on line 0 timed to meet a polarity write at the pending update
    wake_line_in <= 16'h0004;
    cyc(4);
    wr(8'hFF, 8'h00);
    cyc(1);
    wake_line_in <= 16'h0005;
    cyc(1);
    wr(8'hFD, 8'h01);
    cyc(4);
    rd(8'hFF, 8'h00);
    stop_test();
  end
endmodule
bind wiu_top wiu_chk chk (.mclk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
  .ext_int_pin_in, .stop_ack_in, .stop_req_out, .wake_event_out, .channel_out);
`default_nettype wire
